// [fotc_pkg.sv]
package fotc_pkg;

  // Timebase
  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned TICK_MS       = 10;
  localparam int unsigned TICK_CYC_DEF  = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned MINUTE_MS     = 60_000;
  localparam int unsigned MIN_TICKS_DEF = MINUTE_MS / TICK_MS;

  // Widths
  localparam int unsigned FUNC_W = 32;
  localparam int unsigned PIN_W  = FUNC_W + 5;
  localparam int unsigned NCH    = 3;

  // Register offsets
  localparam logic [3:0] REG_TRIP_MASK  = 4'h0;
  localparam logic [3:0] REG_FUNC_SEL   = 4'h1;
  localparam logic [3:0] REG_POLARITY   = 4'h2;
  localparam logic [3:0] REG_GEN_ON     = 4'h3;
  localparam logic [3:0] REG_GEN_OFF    = 4'h4;
  localparam logic [3:0] REG_TRIP_ON    = 4'h5;
  localparam logic [3:0] REG_TRIP_OFF   = 4'h6;
  localparam logic [3:0] REG_TIME_CLR   = 4'h7;
  localparam logic [3:0] REG_FAN_CLR    = 4'h8;
  localparam logic [3:0] REG_ON_TIME    = 4'h9;
  localparam logic [3:0] REG_RUN_TIME   = 4'ha;
  localparam logic [3:0] REG_FAN_TIME   = 4'hb;
  localparam logic [3:0] REG_STATUS     = 4'hc;

  // Field positions
  localparam int unsigned MASK_LOW_V    = 0;
  localparam int unsigned MASK_OTHER    = 1;
  localparam int unsigned MASK_RESTART  = 2;
  localparam int unsigned CH_FIRST_RELAY_OUTPUT     = 0;
  localparam int unsigned CH_RELAY2     = 1;
  localparam int unsigned CH_OC         = 2;
  localparam int unsigned PIN_LOW_V     = FUNC_W;
  localparam int unsigned PIN_RUN       = FUNC_W + 3;
  localparam int unsigned PIN_FAN       = FUNC_W + 4;

  // Reset values and codes
  localparam logic [2:0]  TRIP_MASK_RST = 3'h2;
  localparam logic [2:0]  POLARITY_RST  = 3'h0;
  localparam logic [7:0]  SEL_TRIP      = 8'h1c;
  localparam logic [7:0]  SEL_FIRST_RELAY_OUTPUT_RST = 8'h1c;
  localparam logic [7:0]  SEL_RELAY2_RST = 8'h0e;
  localparam logic [7:0]  SEL_OC_RST    = 8'h01;
  localparam logic [15:0] DELAY_RST     = 16'h0000;

  // Calendar limits
  localparam logic [5:0] MIN_LAST   = 6'h3b;
  localparam logic [4:0] HOUR_LAST  = 5'h17;
  localparam logic [4:0] DAY_LAST   = 5'h1e;
  localparam logic [3:0] MONTH_LAST = 4'hc;

  typedef struct packed {
    logic [7:0] year;
    logic [3:0] month;
    logic [4:0] day;
    logic [4:0] hour;
    logic [5:0] minute;
  } fotc_time_t;

  typedef struct packed {
    logic        active;
    logic [15:0] cnt;
  } fotc_chan_t;

  typedef struct packed {
    logic [PIN_W-1:0] s1;
    logic [PIN_W-1:0] s2;
    logic [PIN_W-1:0] s3;
    logic [PIN_W-1:0] pins;
    logic [2:0]       trip_mask;
    logic [7:0]       sel_r1;
    logic [7:0]       sel_r2;
    logic [7:0]       sel_oc;
    logic [2:0]       polarity;
    logic [15:0]      gen_on;
    logic [15:0]      gen_off;
    logic [15:0]      trip_on;
    logic [15:0]      trip_off;
    logic [23:0]      tick_cnt;
    logic [12:0]      min_cnt;
    fotc_chan_t [NCH-1:0] chan;
    logic [NCH-1:0]   contact;
    fotc_time_t       on_time;
    fotc_time_t       run_time;
    fotc_time_t       fan_time;
    logic [31:0]      rdata;
  } fotc_state_t;

endpackage

// [fotc_output_ctrl.sv]
`timescale 1ns/1ps
// Operation
// [R01] A three-bit trip mask picks low-voltage trips (bit 0), other trips (bit 1), restart failure (bit 2).
// [R02] An output whose selector holds the trip code goes active on a qualifying trip.
// [R03] A trip-assigned output turns on only after the trip on-delay, default zero.
// [R04] A trip-assigned output turns off only after the trip off-delay once the trip clears.
// [R05] A general output turns on only after the general on-delay from its condition rising.
// [R06] A general output turns off only after the general off-delay from its condition falling.
// [R07] On and off delays are held and applied independently.
// [R08] General delays serve both relays and the open collector unless set to trip.
// [R09] Polarity bit 0 gives a normally open contact, 1 a normally closed one, reset zero.
// [R10] Polarity bit 0 is the first relay, the open collector sits in a higher bit.
// [R11] Power-on, run and fan totals count minutes as year, month, day, hour, minute from zero.
// [R12] Power-on time always advances, run time only while running.
// [R13] Writing 1 to the time clear zeroes power-on and run time.
// [R14] Fan time advances only while the fan runs and writing 1 to fan clear zeroes it.
// [R15] Delay timers count a 10 ms tick divided from the system clock.
// [R16] Polarity is applied after the delay stage.
module fotc_output_ctrl #(
  parameter int unsigned TICK_CYCLES = fotc_pkg::TICK_CYC_DEF,
  parameter int unsigned MIN_TICKS   = fotc_pkg::MIN_TICKS_DEF
) (
  // Clock and reset
  input  wire logic                        clk_sys_in,
  input  wire logic                        reset_n_in,
  // Register port
  input  wire logic [3:0]                  reg_addr_in,
  input  wire logic [31:0]                 reg_wdata_in,
  input  wire logic                        reg_wr_in,
  input  wire logic                        reg_rd_in,
  output logic      [31:0]                 reg_rdata_out,
  // Drive conditions, asynchronous
  input  wire logic [fotc_pkg::FUNC_W-1:0] gen_func_in,
  input  wire logic                        low_volt_trip_in,
  input  wire logic                        other_trip_in,
  input  wire logic                        restart_fail_in,
  input  wire logic                        running_in,
  input  wire logic                        fan_running_in,
  // Contacts, 1 = closed
  output logic                             first_relay_output_out,
  output logic                             second_relay_output_out,
  output logic                             open_collector_output_out
);

  fotc_pkg::fotc_state_t r;
  fotc_pkg::fotc_state_t next_r;

  function automatic fotc_pkg::fotc_time_t inc_time(input fotc_pkg::fotc_time_t t);
    fotc_pkg::fotc_time_t n;
    n = t;
    if (t.minute != fotc_pkg::MIN_LAST) begin
      n.minute = t.minute + 6'h01;
    end else begin
      n.minute = 6'h00;
      if (t.hour != fotc_pkg::HOUR_LAST) begin
        n.hour = t.hour + 5'h01;
      end else begin
        n.hour = 5'h00;
        if (t.day != fotc_pkg::DAY_LAST) begin
          n.day = t.day + 5'h01;
        end else begin
          n.day = 5'h00;
          if (t.month != fotc_pkg::MONTH_LAST) begin
            n.month = t.month + 4'h1;
          end else begin
            n.month = 4'h0;
            n.year  = t.year + 8'h01;
          end
        end
      end
    end
    return n;
  endfunction

  function automatic logic wr_hit(input logic [3:0] a);
    return reg_wr_in && (reg_addr_in == a);
  endfunction

  logic                        tick;
  logic                        minute;
  logic [2:0]                  trips;
  logic                        fault;
  logic [fotc_pkg::NCH-1:0]    target;
  logic [fotc_pkg::NCH-1:0]    is_trip;
  logic [7:0]                  sel [fotc_pkg::NCH];
  logic [15:0]                 dly;
  logic [fotc_pkg::NCH-1:0]    next_active;

  always_comb begin
    next_r = r;
    // Change accepted only once the second and third stages agree
    next_r.s1 = {fan_running_in, running_in, restart_fail_in, other_trip_in,
                 low_volt_trip_in, gen_func_in};
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    for (int i = 0; i < fotc_pkg::PIN_W; i++) begin
      if (r.s2[i] == r.s3[i]) begin
        next_r.pins[i] = r.s3[i];
      end
    end

    // 10 ms timebase and minute tick
    tick = (r.tick_cnt == 24'(TICK_CYCLES - 1)); // [R15]
    next_r.tick_cnt = tick ? 24'h000000 : r.tick_cnt + 24'h000001;
    minute = tick && (r.min_cnt == 13'(MIN_TICKS - 1));
    if (tick) begin
      next_r.min_cnt = minute ? 13'h0000 : r.min_cnt + 13'h0001;
    end

    // Trip qualification
    trips = r.pins[fotc_pkg::PIN_LOW_V +: 3];
    fault = |(trips & r.trip_mask); // [R01]

    sel[fotc_pkg::CH_FIRST_RELAY_OUTPUT] = r.sel_r1;
    sel[fotc_pkg::CH_RELAY2] = r.sel_r2;
    sel[fotc_pkg::CH_OC]     = r.sel_oc;
    for (int c = 0; c < fotc_pkg::NCH; c++) begin
      is_trip[c] = (sel[c] == fotc_pkg::SEL_TRIP);
      // Unknown selector codes read as an idle condition
      if (is_trip[c]) begin
        target[c] = fault; // [R02]
      end else if (sel[c] < 8'(fotc_pkg::FUNC_W)) begin
        target[c] = r.pins[sel[c][4:0]];
      end else begin
        target[c] = 1'b0;
      end
      // Trip outputs use only trip delays, others the general pair
      if (is_trip[c]) begin // [R08]
        dly = target[c] ? r.trip_on : r.trip_off; // [R03] [R04] [R07]
      end else begin
        dly = target[c] ? r.gen_on : r.gen_off; // [R05] [R06] [R07]
      end
      next_active[c] = r.chan[c].active;
      if (target[c] == r.chan[c].active) begin
        next_r.chan[c].cnt = 16'h0000;
      end else if ((dly == 16'h0000) || (tick && (r.chan[c].cnt + 16'h0001 >= dly))) begin
        next_active[c]     = target[c];
        next_r.chan[c].cnt = 16'h0000;
      end else if (tick) begin
        next_r.chan[c].cnt = r.chan[c].cnt + 16'h0001;
      end
      next_r.chan[c].active = next_active[c];
      // Form A closes when active, form B opens
      next_r.contact[c] = next_active[c] ^ r.polarity[c]; // [R09] [R10] [R16]
    end

    // Operating time totals
    if (minute) begin
      next_r.on_time = inc_time(r.on_time); // [R11] [R12]
      if (r.pins[fotc_pkg::PIN_RUN]) begin
        next_r.run_time = inc_time(r.run_time); // [R12]
      end
      if (r.pins[fotc_pkg::PIN_FAN]) begin
        next_r.fan_time = inc_time(r.fan_time); // [R14]
      end
    end
    // Clear beats a coinciding minute step so the total reads zero
    if (wr_hit(fotc_pkg::REG_TIME_CLR) && reg_wdata_in[0]) begin
      next_r.on_time  = '0; // [R13]
      next_r.run_time = '0; // [R13]
    end
    if (wr_hit(fotc_pkg::REG_FAN_CLR) && reg_wdata_in[0]) begin
      next_r.fan_time = '0; // [R14]
    end

    // Register writes
    if (wr_hit(fotc_pkg::REG_TRIP_MASK)) begin
      next_r.trip_mask = reg_wdata_in[2:0];
    end
    if (wr_hit(fotc_pkg::REG_FUNC_SEL)) begin
      next_r.sel_r1 = reg_wdata_in[7:0];
      next_r.sel_r2 = reg_wdata_in[15:8];
      next_r.sel_oc = reg_wdata_in[23:16];
    end
    if (wr_hit(fotc_pkg::REG_POLARITY)) begin
      next_r.polarity = reg_wdata_in[2:0];
    end
    if (wr_hit(fotc_pkg::REG_GEN_ON)) begin
      next_r.gen_on = reg_wdata_in[15:0];
    end
    if (wr_hit(fotc_pkg::REG_GEN_OFF)) begin
      next_r.gen_off = reg_wdata_in[15:0];
    end
    if (wr_hit(fotc_pkg::REG_TRIP_ON)) begin
      next_r.trip_on = reg_wdata_in[15:0];
    end
    if (wr_hit(fotc_pkg::REG_TRIP_OFF)) begin
      next_r.trip_off = reg_wdata_in[15:0];
    end

    // Read data stands one cycle only
    next_r.rdata = 32'h00000000;
    if (reg_rd_in) begin
      case (reg_addr_in)
        fotc_pkg::REG_TRIP_MASK: next_r.rdata = {29'h0, r.trip_mask};
        fotc_pkg::REG_FUNC_SEL:  next_r.rdata = {8'h00, r.sel_oc, r.sel_r2, r.sel_r1};
        fotc_pkg::REG_POLARITY:  next_r.rdata = {29'h0, r.polarity};
        fotc_pkg::REG_GEN_ON:    next_r.rdata = {16'h0000, r.gen_on};
        fotc_pkg::REG_GEN_OFF:   next_r.rdata = {16'h0000, r.gen_off};
        fotc_pkg::REG_TRIP_ON:   next_r.rdata = {16'h0000, r.trip_on};
        fotc_pkg::REG_TRIP_OFF:  next_r.rdata = {16'h0000, r.trip_off};
        fotc_pkg::REG_ON_TIME:   next_r.rdata = {4'h0, r.on_time};
        fotc_pkg::REG_RUN_TIME:  next_r.rdata = {4'h0, r.run_time};
        fotc_pkg::REG_FAN_TIME:  next_r.rdata = {4'h0, r.fan_time};
        fotc_pkg::REG_STATUS: begin
          next_r.rdata = {20'h0, r.pins[fotc_pkg::PIN_FAN], r.pins[fotc_pkg::PIN_RUN],
                          trips, fault, r.contact,
                          r.chan[2].active, r.chan[1].active, r.chan[0].active};
        end
        default: next_r.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      r           <= '0;
      r.trip_mask <= fotc_pkg::TRIP_MASK_RST;
      r.sel_r1    <= fotc_pkg::SEL_FIRST_RELAY_OUTPUT_RST;
      r.sel_r2    <= fotc_pkg::SEL_RELAY2_RST;
      r.sel_oc    <= fotc_pkg::SEL_OC_RST;
      r.polarity  <= fotc_pkg::POLARITY_RST;
      r.gen_on    <= fotc_pkg::DELAY_RST;
      r.gen_off   <= fotc_pkg::DELAY_RST;
      r.trip_on   <= fotc_pkg::DELAY_RST;
      r.trip_off  <= fotc_pkg::DELAY_RST;
    end else begin
      r <= next_r;
    end
  end

  assign reg_rdata_out             = r.rdata;
  assign first_relay_output_out    = r.contact[fotc_pkg::CH_FIRST_RELAY_OUTPUT];
  assign second_relay_output_out   = r.contact[fotc_pkg::CH_RELAY2];
  assign open_collector_output_out = r.contact[fotc_pkg::CH_OC];

endmodule // fotc_output_ctrl

// [fotc_output_ctrl_asserts.sv]
`timescale 1ns/1ps
module fotc_output_ctrl_chk (
  // Clock and reset
  input wire logic        clk_sys_in,
  input wire logic        reset_n_in,
  // Register port
  input wire logic [3:0]  reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic        reg_wr_in,
  input wire logic        reg_rd_in,
  input wire logic [31:0] reg_rdata_out,
  // Contacts
  input wire logic        first_relay_output_out,
  input wire logic        second_relay_output_out,
  input wire logic        open_collector_output_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);

  // Write then read of one offset returns the written field
  property p_wr_rd(logic [3:0] a, logic [31:0] m);
    reg_wr_in && reg_addr_in == a ##1 reg_rd_in && reg_addr_in == a
      |=> reg_rdata_out == ($past(reg_wdata_in, 2) & m);
  endproperty

  a_mask_hold: assert property (p_wr_rd(fotc_pkg::REG_TRIP_MASK, 32'h7))
    else $error("trip mask readback wrong");
  a_sel_hold: assert property (p_wr_rd(fotc_pkg::REG_FUNC_SEL, 32'hffffff))
    else $error("selector readback wrong");
  a_pol_hold: assert property (p_wr_rd(fotc_pkg::REG_POLARITY, 32'h7))
    else $error("polarity readback wrong");
  a_delay_hold: assert property (p_wr_rd(fotc_pkg::REG_TRIP_ON, 32'hffff))
    else $error("on delay readback wrong");
  // The read takes the total the clear left, which a minute cannot raise; one count is still tolerated
  a_time_clear: assert property (reg_wr_in && reg_addr_in == fotc_pkg::REG_TIME_CLR
    && reg_wdata_in[0] ##1 reg_rd_in && reg_addr_in == fotc_pkg::REG_RUN_TIME
    |=> reg_rdata_out < 32'h2) else $error("run time not cleared");
  a_fan_clear: assert property (reg_wr_in && reg_addr_in == fotc_pkg::REG_FAN_CLR
    && reg_wdata_in[0] ##1 reg_rd_in && reg_addr_in == fotc_pkg::REG_FAN_TIME
    |=> reg_rdata_out < 32'h2) else $error("fan time not cleared");
  a_status_pins: assert property (reg_rd_in && reg_addr_in == fotc_pkg::REG_STATUS
    |=> reg_rdata_out[5:3] == $past({open_collector_output_out,
    second_relay_output_out, first_relay_output_out})) else $error("status contacts wrong");
  a_reset_open: assert property ($rose(reset_n_in) |-> !first_relay_output_out
    && !second_relay_output_out && !open_collector_output_out)
    else $error("contact closed after reset");

  c_trip_on: cover property ($rose(first_relay_output_out));
  c_oc_on: cover property ($rose(open_collector_output_out));
  c_time_clr: cover property (reg_wr_in && reg_addr_in == fotc_pkg::REG_TIME_CLR);
endmodule // fotc_output_ctrl_chk

bind fotc_output_ctrl fotc_output_ctrl_chk chk_u (.clk_sys_in, .reset_n_in, .reg_addr_in,
  .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .first_relay_output_out,
  .second_relay_output_out, .open_collector_output_out);

// [fotc_load_model.sv]
`timescale 1ns/1ps
module fotc_load_model (
  // Clock
  input  wire logic       clk_sys_in,
  // Contacts in, lamp state out
  input  wire logic [2:0] contact_in,
  output logic      [2:0] load_on_out
);
  // Lamp follows its contact one clock late, like a slow coil
  always_ff @(posedge clk_sys_in) begin
    load_on_out <= contact_in;
  end
endmodule // fotc_load_model

// [fotc_output_ctrl_tb_top.sv]
`timescale 1ns/1ps
module fotc_output_ctrl_tb_top;
  logic        clk_sys_in = 1'b0;
  logic        reset_n_in = 1'b0;
  logic [3:0]  addr       = 4'h0;
  logic [31:0] wdata      = 32'h0;
  logic [31:0] gen        = 32'h0;
  logic [31:0] rdata;
  logic [31:0] v;
  logic        wr         = 1'b0;
  logic        rd         = 1'b0;
  logic        running    = 1'b0;
  logic        fan        = 1'b0;
  logic [2:0]  trips      = 3'h0;
  logic [2:0]  contact;
  logic [2:0]  load;
  int          num_errors = 0;
  int          compares   = 0;
  int          n;

  always #25 clk_sys_in = ~clk_sys_in;

  // Short tick and minute keep the run brief
  fotc_output_ctrl #(.TICK_CYCLES(4), .MIN_TICKS(2)) dut_u (.clk_sys_in(clk_sys_in),
    .reset_n_in(reset_n_in), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_rdata_out(rdata), .gen_func_in(gen), .low_volt_trip_in(trips[0]),
    .other_trip_in(trips[1]), .restart_fail_in(trips[2]), .running_in(running),
    .fan_running_in(fan), .first_relay_output_out(contact[0]),
    .second_relay_output_out(contact[1]), .open_collector_output_out(contact[2]));
  fotc_load_model load_u (.clk_sys_in(clk_sys_in), .contact_in(contact), .load_on_out(load));

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Strobe left high; the next read or cyc drops it
  task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
  endtask
  task automatic bus_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_sys_in);
    wr <= 1'b0;
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_sys_in);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
    bus_rd(a, v);
    chk(v, e);
  endtask
  task automatic cyc(input int c);
    repeat (c) begin
      @(posedge clk_sys_in);
      wr <= 1'b0;
    end
  endtask
  task automatic wait_load(input int i, input logic l, output int c);
    c = 0;
    while (load[i] !== l && c < 200) begin
      @(posedge clk_sys_in);
      #1 c++;
    end
  endtask

  task automatic t_reset;
    rd_chk(fotc_pkg::REG_TRIP_MASK, 32'h2);
    rd_chk(fotc_pkg::REG_POLARITY, 32'h0);
    for (int a = 3; a < 7; a++) rd_chk(4'(a), 32'h0);
    rd_chk(4'hd, 32'h0);
    bus_wr(fotc_pkg::REG_FUNC_SEL, 32'h010e1c);
    rd_chk(fotc_pkg::REG_FUNC_SEL, 32'h010e1c);
    chk(32'(load), 32'h0);
  endtask
  task automatic t_mask;
    for (int i = 0; i < 3; i++) begin
      bus_wr(fotc_pkg::REG_TRIP_MASK, 32'(1 << i));
      rd_chk(fotc_pkg::REG_TRIP_MASK, 32'(1 << i));
      for (int j = 0; j < 3; j++) begin
        trips <= 3'(1 << j);
        cyc(10);
        chk(32'(load[0]), 32'(i == j));
        trips <= 3'h0;
        cyc(10);
      end
    end
    bus_wr(fotc_pkg::REG_TRIP_MASK, 32'h2);
  endtask
  // Large general delay must not slow a trip output
  task automatic t_trip;
    bus_wr(fotc_pkg::REG_GEN_ON, 32'd100);
    bus_wr(fotc_pkg::REG_TRIP_OFF, 32'd6);
    bus_wr(fotc_pkg::REG_TRIP_ON, 32'd3);
    rd_chk(fotc_pkg::REG_TRIP_ON, 32'd3);
    trips <= 3'h2;
    wait_load(0, 1'b1, n);
    chk(32'(n >= 12 && n <= 23), 32'h1);
    trips <= 3'h0;
    wait_load(0, 1'b0, n);
    chk(32'(n >= 24 && n <= 35), 32'h1);
  endtask
  task automatic t_gen;
    bus_wr(fotc_pkg::REG_GEN_ON, 32'd4);
    bus_wr(fotc_pkg::REG_GEN_OFF, 32'd0);
    cyc(1);
    gen <= 32'h4000;
    wait_load(1, 1'b1, n);
    chk(32'(n >= 16 && n <= 27), 32'h1);
    gen <= 32'h0;
    wait_load(1, 1'b0, n);
    chk(32'(n >= 4 && n <= 9), 32'h1);
  endtask
  task automatic t_pol;
    bus_wr(fotc_pkg::REG_GEN_ON, 32'd0);
    bus_wr(fotc_pkg::REG_POLARITY, 32'h5);
    rd_chk(fotc_pkg::REG_POLARITY, 32'h5);
    cyc(4);
    chk(32'(load), 32'h5);
    bus_rd(fotc_pkg::REG_STATUS, v);
    chk(32'(v[5:3]), 32'h5);
    gen <= 32'h2;
    cyc(12);
    chk(32'(load), 32'h1);
    gen <= 32'h0;
    bus_wr(fotc_pkg::REG_POLARITY, 32'h0);
    cyc(12);
    chk(32'(load), 32'h0);
  endtask
  // Trip on the open collector, code 32 idles relay 2, then a reset mid-run
  task automatic t_sel;
    bus_wr(fotc_pkg::REG_FUNC_SEL, 32'h1c201c);
    bus_wr(fotc_pkg::REG_POLARITY, 32'h7);
    cyc(1);
    gen   <= 32'hffffffff;
    trips <= 3'h2;
    cyc(30);
    chk(32'(load), 32'h2);
    reset_n_in <= 1'b0;
    cyc(2);
    chk(32'(load), 32'h0);
    reset_n_in <= 1'b1;
    rd_chk(fotc_pkg::REG_FUNC_SEL, 32'h010e1c);
    rd_chk(fotc_pkg::REG_POLARITY, 32'h0);
    rd_chk(fotc_pkg::REG_TRIP_ON, 32'h0);
    cyc(10);
    chk(32'(load), 32'h7);
    trips <= 3'h0;
    gen   <= 32'h0;
    cyc(10);
    chk(32'(load), 32'h0);
  endtask
  task automatic t_time;
    bus_wr(fotc_pkg::REG_TIME_CLR, 32'h1);
    bus_rd(fotc_pkg::REG_RUN_TIME, v);
    bus_wr(fotc_pkg::REG_FAN_CLR, 32'h1);
    bus_rd(fotc_pkg::REG_FAN_TIME, v);
    cyc(100);
    bus_rd(fotc_pkg::REG_ON_TIME, v);
    chk(32'(v > 32'd10 && v < 32'd15), 32'h1);
    rd_chk(fotc_pkg::REG_RUN_TIME, 32'h0);
    rd_chk(fotc_pkg::REG_FAN_TIME, 32'h0);
    running <= 1'b1;
    fan <= 1'b1;
    cyc(500);
    bus_rd(fotc_pkg::REG_RUN_TIME, v);
    chk(32'(v[10:6]), 32'h1);
    bus_wr(fotc_pkg::REG_TIME_CLR, 32'h1);
    bus_rd(fotc_pkg::REG_ON_TIME, v);
    chk(32'(v < 32'h2), 32'h1);
    bus_rd(fotc_pkg::REG_FAN_TIME, v);
    chk(32'(v[10:6]), 32'h1);
    bus_wr(fotc_pkg::REG_FAN_CLR, 32'h1);
    bus_rd(fotc_pkg::REG_FAN_TIME, v);
    chk(32'(v < 32'h2), 32'h1);
  endtask

  task automatic complete_run;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge clk_sys_in);
    reset_n_in <= 1'b1;
    t_reset();
    t_mask();
    t_trip();
    t_gen();
    t_pol();
    t_sel();
    t_time();
    cyc(2);
    complete_run();
  end
  // Whole sequence needs about 1000 cycles
  initial begin
    #500_000;
    num_errors++;
    complete_run();
  end
endmodule // fotc_output_ctrl_tb_top
